//--- hw/sic_pkg.sv
// shared constants and types for the script interrupt control block
package sic_pkg;

   // ----------------------------------------------------------------
   // command frame layout
   // ----------------------------------------------------------------
   localparam int unsigned FRAME_LEN      = 9;        // bytes per command frame
   localparam logic [3:0]  FRAME_LAST_IDX = 4'h8;     // index of the checksum byte
   localparam logic [3:0]  IDX_ADDR       = 4'h0;     // target address byte
   localparam logic [3:0]  IDX_CMD        = 4'h1;     // instruction code byte
   localparam logic [3:0]  IDX_TYPE       = 4'h2;     // type byte (interrupt number)
   localparam logic [3:0]  IDX_VAL_FIRST  = 4'h4;     // value byte 3 (most significant)

   // ----------------------------------------------------------------
   // instruction codes handled here
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_IRQ_ENABLE  = 8'h19;    // interrupt_enable_cmd, 25
   localparam logic [7:0] CMD_IRQ_DISABLE = 8'h1a;    // interrupt_disable_cmd, 26
   localparam logic [7:0] CMD_VECTOR_DEFINE_CMD_DEF    = 8'h25;    // vector_define_cmd, 37
   localparam logic [7:0] CMD_HANDLER_RET = 8'h26;    // handler_return_cmd, 38
   localparam logic [7:0] IRQ_GLOBAL      = 8'hff;    // number acting as global switch

   // ----------------------------------------------------------------
   // reply status codes
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_OK       = 8'h64;    // 100, command done
   localparam logic [7:0] STATUS_BAD_CSUM = 8'h01;    // frame checksum mismatch

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic       RST_GLOBAL_EN   = 1'b0;     // interrupt processing off
   localparam logic       RST_ACTIVE      = 1'b0;     // no handler running
   localparam logic [3:0] RST_BYTE_CNT    = 4'h0;     // frame assembly at byte 0

   // dispatch sequencer states
   typedef enum logic [0:0] {SIC_IDLE, SIC_VREAD} sic_state_e;

endpackage : sic_pkg

//--- hw/sic_vec_if.sv
// carrier between the interrupt sequencer and its vector table
`timescale 1ns/1ps
interface sic_vec_if #(
   parameter int AW = 5,                 // index width
   parameter int DW = 16                 // handler entry address width
);
   logic          wr_en;                 // store a handler entry
   logic [AW-1:0] wr_idx;                // interrupt number written
   logic [DW-1:0] wr_data;               // handler entry address
   logic          rd_en;                 // fetch an entry
   logic [AW-1:0] rd_idx;                // interrupt number read
   logic [DW-1:0] rd_data;               // registered read data, one cycle later

   modport ctrl (output wr_en, output wr_idx, output wr_data,
                 output rd_en, output rd_idx, input rd_data);
   modport mem  (input wr_en, input wr_idx, input wr_data,
                 input rd_en, input rd_idx, output rd_data);
endinterface : sic_vec_if

//--- hw/sic_vector_mem.sv
// handler entry address table, registered read port
`timescale 1ns/1ps
module sic_vector_mem #(
   parameter int DEPTH = 32              // number of interrupt sources
)(
   // clock
   input wire logic clk,
   // table port
   sic_vec_if.mem   vp
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // no reset on the array: an entry is only used after software defines it
   logic [$bits(vp.wr_data)-1:0] mem_reg [DEPTH];   // entry addresses
   logic [$bits(vp.wr_data)-1:0] rd_data_reg;       // read data register

   // write on request, read into a register so the output is a flop
   always_ff @(posedge clk)
   begin
      if (vp.wr_en)
      begin
         mem_reg[vp.wr_idx] <= vp.wr_data;
      end
      if (vp.rd_en)
      begin
         rd_data_reg <= mem_reg[vp.rd_idx];
      end
   end

   assign vp.rd_data = rd_data_reg;

endmodule : sic_vector_mem

//--- hw/sic_ctrl.sv
// script interrupt control: frame decode, enables, vectors, dispatch and return
`timescale 1ns/1ps
module sic_ctrl
   import sic_pkg::*;
#(
   parameter int         NUM_IRQ = 32,      // interrupt sources
   parameter int         PC_W    = 16,      // program counter width
   parameter logic [7:0] MY_ADDR = 8'h01    // target address of this device
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // command byte stream, same clock
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   input  wire logic              direct_mode,
   // interrupt events, one-cycle pulses, same clock
   input  wire logic [NUM_IRQ-1:0] irq_event,
   // interpreter context to save
   input  wire logic [31:0]       acc_in,
   input  wire logic [31:0]       xreg_in,
   input  wire logic [7:0]        flags_in,
   input  wire logic [PC_W-1:0]   pc_in,
   // reply to the host
   output logic                   reply_valid,
   output logic [7:0]             reply_status,
   output logic [7:0]             reply_cmd,
   // handler entry
   output logic                   jump_valid,
   output logic [PC_W-1:0]        jump_addr,
   // handler return
   output logic                   restore_valid,
   output logic [31:0]            acc_out,
   output logic [31:0]            xreg_out,
   output logic [7:0]             flags_out,
   output logic [PC_W-1:0]        pc_out,
   // status
   output logic                   global_en,
   output logic                   handler_active,
   output logic [NUM_IRQ-1:0]     irq_enabled
);
   localparam int AW = $clog2(NUM_IRQ);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [3:0]         cnt_reg,  cnt_next;       // byte index inside the frame
   logic [7:0]         sum_reg,  sum_next;       // running modulo-256 sum
   logic               addr_ok_reg, addr_ok_next;// frame is for us
   logic [7:0]         cmd_reg,  cmd_next;       // instruction code
   logic [7:0]         type_reg, type_next;      // interrupt number
   logic [31:0]        val_reg,  val_next;       // value field
   logic [NUM_IRQ-1:0] en_reg,   en_next;        // per-source enables
   logic [NUM_IRQ-1:0] pend_reg, pend_next;      // caught events
   logic               gen_reg,  gen_next;       // global processing enable
   logic               act_reg,  act_next;       // handler running
   sic_state_e         st_reg,   st_next;        // dispatch sequencer
   logic [AW-1:0]      sel_reg,  sel_next;       // source being dispatched
   logic               rep_v_reg, rep_v_next;    // reply strobe
   logic [7:0]         rep_s_reg, rep_s_next;    // reply status
   logic [7:0]         rep_c_reg, rep_c_next;    // reply code
   logic               jmp_reg,  jmp_next;       // jump strobe
   logic               rst_v_reg, rst_v_next;    // restore strobe
   logic [31:0]        sacc_reg, sacc_next;      // saved accumulator
   logic [31:0]        sx_reg,   sx_next;        // saved X register
   logic [7:0]         sfl_reg,  sfl_next;       // saved flags
   logic [PC_W-1:0]    spc_reg,  spc_next;       // saved program counter

   // decode of the frame that completes this cycle
   logic       last_byte;                        // checksum byte arriving
   logic       frame_ok;                         // good frame for us
   logic       ours;                             // code belongs to this block
   logic       src_ok;                           // type byte names a real source
   logic [AW-1:0] src_idx;                       // source index from type byte

   sic_vec_if #(.AW(AW), .DW(PC_W)) vif ();

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // lowest numbered pending source wins
   function automatic logic [AW-1:0] first_set(input logic [NUM_IRQ-1:0] v);
      logic [AW-1:0] r;
      r = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = AW'(i);
         end
      end
      return r;
   endfunction : first_set

   // the four codes this block answers for
   function automatic logic is_ours(input logic [7:0] c);
      return (c == CMD_IRQ_ENABLE) || (c == CMD_IRQ_DISABLE) ||
             (c == CMD_VECTOR_DEFINE_CMD_DEF) || (c == CMD_HANDLER_RET);
   endfunction : is_ours

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      cnt_next = cnt_reg;   sum_next = sum_reg;   addr_ok_next = addr_ok_reg;
      cmd_next = cmd_reg;   type_next = type_reg; val_next = val_reg;
      en_next = en_reg;     gen_next = gen_reg;   act_next = act_reg;
      st_next = st_reg;     sel_next = sel_reg;
      rep_v_next = 1'b0;    rep_s_next = rep_s_reg; rep_c_next = rep_c_reg;
      jmp_next = 1'b0;      rst_v_next = 1'b0;
      sacc_next = sacc_reg; sx_next = sx_reg; sfl_next = sfl_reg; spc_next = spc_reg;
      // decode first: the table port below reads the source index
      last_byte = rx_valid && (cnt_reg == FRAME_LAST_IDX);
      ours      = is_ours(cmd_reg);
      src_idx   = type_reg[AW-1:0];
      src_ok    = (32'(type_reg) < NUM_IRQ);
      vif.wr_en = 1'b0;     vif.wr_idx = src_idx; vif.wr_data = val_reg[PC_W-1:0];
      vif.rd_en = 1'b0;     vif.rd_idx = first_set(pend_reg & en_reg);
      frame_ok  = last_byte && addr_ok_reg && (sum_reg == rx_data);

      if (rx_valid)
      begin
         sum_next = sum_reg + rx_data;
         cnt_next = cnt_reg + 4'h1;
         case (cnt_reg)
            IDX_ADDR: addr_ok_next = (rx_data == MY_ADDR);
            IDX_CMD:  cmd_next = rx_data;
            IDX_TYPE: type_next = rx_data;
            default:  if (cnt_reg >= IDX_VAL_FIRST)
                      begin
                         val_next = {val_reg[23:0], rx_data};
                      end
         endcase
         if (last_byte)
         begin
            cnt_next = RST_BYTE_CNT;
            sum_next = 8'h00;
         end
      end

      // replies only in direct mode, only for our codes addressed to us
      if (last_byte && addr_ok_reg && ours && direct_mode)
      begin
         rep_v_next = 1'b1;
         rep_c_next = cmd_reg;
         rep_s_next = frame_ok ? STATUS_OK : STATUS_BAD_CSUM;
      end

      if (frame_ok)
      begin
         case (cmd_reg)
            CMD_IRQ_ENABLE:
            begin
               if (type_reg == IRQ_GLOBAL) gen_next = 1'b1;
               else if (src_ok) en_next[src_idx] = 1'b1;
            end
            CMD_IRQ_DISABLE:
            begin
               if (type_reg == IRQ_GLOBAL) gen_next = 1'b0;
               else if (src_ok) en_next[src_idx] = 1'b0;
            end
            CMD_VECTOR_DEFINE_CMD_DEF:
            begin
               vif.wr_en = src_ok;
            end
            CMD_HANDLER_RET:
            begin
               if (act_reg)
               begin
                  act_next   = 1'b0;
                  rst_v_next = 1'b1;
               end
            end
            default: ;
         endcase
      end

      case (st_reg)
         SIC_IDLE:
            if (gen_reg && !act_reg && |(pend_reg & en_reg))
            begin
               vif.rd_en = 1'b1;
               sel_next  = vif.rd_idx;
               st_next   = SIC_VREAD;
            end
         SIC_VREAD:
         begin
            jmp_next  = 1'b1;
            act_next  = 1'b1;
            sacc_next = acc_in;
            sx_next   = xreg_in;
            sfl_next  = flags_in;
            spc_next  = pc_in;
            st_next   = SIC_IDLE;
         end
         default: st_next = SIC_IDLE;
      endcase

      // events only latch for enabled sources; a new event beats the clear
      pend_next = pend_reg & en_next;
      if (st_reg == SIC_VREAD)
      begin
         pend_next[sel_reg] = 1'b0;
      end
      pend_next = pend_next | (irq_event & en_next);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_reg <= RST_BYTE_CNT; sum_reg <= 8'h00; addr_ok_reg <= 1'b0;
         cmd_reg <= 8'h00; type_reg <= 8'h00; val_reg <= 32'h0;
         en_reg <= '0; pend_reg <= '0; gen_reg <= RST_GLOBAL_EN; act_reg <= RST_ACTIVE;
         st_reg <= SIC_IDLE; sel_reg <= '0;
         rep_v_reg <= 1'b0; rep_s_reg <= 8'h00; rep_c_reg <= 8'h00;
         jmp_reg <= 1'b0; rst_v_reg <= 1'b0;
         sacc_reg <= 32'h0; sx_reg <= 32'h0; sfl_reg <= 8'h00; spc_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_next; sum_reg <= sum_next; addr_ok_reg <= addr_ok_next;
         cmd_reg <= cmd_next; type_reg <= type_next; val_reg <= val_next;
         en_reg <= en_next; pend_reg <= pend_next; gen_reg <= gen_next; act_reg <= act_next;
         st_reg <= st_next; sel_reg <= sel_next;
         rep_v_reg <= rep_v_next; rep_s_reg <= rep_s_next; rep_c_reg <= rep_c_next;
         jmp_reg <= jmp_next; rst_v_reg <= rst_v_next;
         sacc_reg <= sacc_next; sx_reg <= sx_next; sfl_reg <= sfl_next; spc_reg <= spc_next;
      end
   end

   sic_vector_mem #(.DEPTH(NUM_IRQ)) u_vec (
      .clk (clk),
      .vp  (vif.mem)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reply_valid    = rep_v_reg;
   assign reply_status   = rep_s_reg;
   assign reply_cmd      = rep_c_reg;
   assign jump_valid     = jmp_reg;
   assign jump_addr      = vif.rd_data;   // held until the next table read
   assign restore_valid  = rst_v_reg;
   assign acc_out        = sacc_reg;
   assign xreg_out       = sx_reg;
   assign flags_out      = sfl_reg;
   assign pc_out         = spc_reg;
   assign global_en      = gen_reg;
   assign handler_active = act_reg;
   assign irq_enabled    = en_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_dispatch_start;
      st_reg == SIC_IDLE && gen_reg && !act_reg && |(pend_reg & en_reg);
   endsequence
   sequence s_enter_handler;
      jump_valid && handler_active && !global_en == 1'b0;
   endsequence

   a_enable_source: assert property (frame_ok && cmd_reg == CMD_IRQ_ENABLE && src_ok
      && type_reg != IRQ_GLOBAL |=> irq_enabled[$past(src_idx)])
      else $error("source not enabled");
   a_global_on: assert property (frame_ok && cmd_reg == CMD_IRQ_ENABLE
      && type_reg == IRQ_GLOBAL |=> global_en)
      else $error("global enable not set");
   a_disable_source: assert property (frame_ok && cmd_reg == CMD_IRQ_DISABLE && src_ok
      && type_reg != IRQ_GLOBAL |=> !irq_enabled[$past(src_idx)])
      else $error("source not disabled");
   a_global_off: assert property (frame_ok && cmd_reg == CMD_IRQ_DISABLE
      && type_reg == IRQ_GLOBAL |=> !global_en ##1 !jump_valid)
      else $error("global enable not cleared");
   a_vector_store: assert property (frame_ok && cmd_reg == CMD_VECTOR_DEFINE_CMD_DEF && src_ok
      |-> vif.wr_en && vif.wr_data == val_reg[PC_W-1:0])
      else $error("vector not written");
   a_return_restore: assert property (frame_ok && cmd_reg == CMD_HANDLER_RET && act_reg
      |=> restore_valid && !handler_active && pc_out == $past(spc_reg))
      else $error("return did not restore");
   a_bad_sum: assert property (last_byte && sum_reg != rx_data
      |=> $stable(global_en) && $stable(irq_enabled) && !restore_valid)
      else $error("bad frame acted on");
   a_dispatch_jump: assert property (s_dispatch_start |=> ##1 s_enter_handler
      ##0 pc_out == $past(pc_in))
      else $error("dispatch did not enter handler");
   a_frame_index: assert property (cnt_reg <= FRAME_LAST_IDX)
      else $error("frame index out of range");

endmodule : sic_ctrl

//--- sim/sic_host.sv
// partner model: host issuing nine-byte command frames
`timescale 1ns/1ps
module sic_host (
   // clock
   input  wire logic clk,
   // byte stream towards the block
   output logic       rx_valid,
   output logic [7:0] rx_data
);
   // idle line at time zero
   initial
   begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   // ------------------------------------------------------------
   // one frame, bytes back to back on falling edges
   // ------------------------------------------------------------
   task automatic send(input logic [7:0] addr, input logic [7:0] cmd,
                       input logic [7:0] typ, input logic [7:0] bank,
                       input logic [31:0] val, input logic bad);
      logic [7:0] f [9];
      f = '{addr, cmd, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      // checksum is byte sum, spoilt on demand
      for (int k = 0; k < 8; k++)
         f[8] = f[8] + f[k];
      if (bad)
         f[8] = f[8] ^ 8'h5a;
      for (int k = 0; k < 9; k++)
      begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data  = f[k];
      end
      // released line shows no stale byte
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
   endtask : send
endmodule : sic_host

//--- sim/testbench.sv
// self-checking bench for the script interrupt control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench
   import sic_pkg::*;
;
   localparam logic [7:0] DEV = 8'h01;       // address of the block
   logic        clk, rst, direct_mode;       // clock, reset, reply mode
   logic        rx_valid;                    // byte strobe from host
   logic [7:0]  rx_data;                     // byte from host
   logic [31:0] irq_event, acc_in, xreg_in;  // events and context
   logic [7:0]  flags_in;                    // flags context
   logic [15:0] pc_in;                       // program counter context
   logic        reply_valid, jump_valid, restore_valid;
   logic [7:0]  reply_status, reply_cmd, flags_out;
   logic [15:0] jump_addr, pc_out;
   logic [31:0] acc_out, xreg_out, irq_enabled;
   logic        global_en, handler_active;
   logic [63:0] q [$];                       // expected events, oldest first
   logic [15:0] vec [32];                    // model of the vector table
   logic [31:0] seed = 32'h934b;             // xorshift state
   logic [63:0] ctx;                         // expected restore note
   int          miscompares, samples_checked, cycles;

   sic_host host_i (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data));

   sic_ctrl #(.NUM_IRQ(32), .PC_W(16), .MY_ADDR(DEV)) sic_ctrl_i (
      .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
      .direct_mode(direct_mode), .irq_event(irq_event), .acc_in(acc_in),
      .xreg_in(xreg_in), .flags_in(flags_in), .pc_in(pc_in),
      .reply_valid(reply_valid), .reply_status(reply_status), .reply_cmd(reply_cmd),
      .jump_valid(jump_valid), .jump_addr(jump_addr), .restore_valid(restore_valid),
      .acc_out(acc_out), .xreg_out(xreg_out), .flags_out(flags_out), .pc_out(pc_out),
      .global_en(global_en), .handler_active(handler_active), .irq_enabled(irq_enabled));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // one frame; notes the reply, then an optional follow-up event
   task automatic cmd(input logic [7:0] c, input logic [7:0] t, input logic [31:0] v,
                      input logic bad, input logic [63:0] extra);
      logic [31:0] b;
      b = rnd();
      if (direct_mode)
         q.push_back({8'h1, 40'h0, (bad ? STATUS_BAD_CSUM : STATUS_OK), c});
      if (extra != 64'h0)
         q.push_back(extra);
      host_i.send(DEV, c, t, b[7:0], v, bad);
      @(negedge clk);
   endtask : cmd

   // one-cycle event pulse
   task automatic pulse(input logic [31:0] m);
      @(negedge clk);
      irq_event = m;
      @(negedge clk);
      irq_event = 32'h0;
   endtask : pulse

   // new context, remembered as the next restore note
   task automatic new_ctx;
      {acc_in, xreg_in} = {rnd(), rnd()};
      {flags_in, pc_in} = 24'(rnd());
      ctx = {8'h3, flags_in, pc_in, acc_in};
   endtask : new_ctx

   // ------------------------------------------------------------
   // clock, timeout and output watcher
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         stop_test();
      end
   end

   // each result is matched with the oldest note; a surprise result fails
   task automatic take(input logic [63:0] got);
      logic [63:0] e;
      e = (q.size() != 0) ? q.pop_front() : 64'h0;
      `CHK("event", e, got);
   endtask : take

   always @(posedge clk)
   begin
      #1;
      if (reply_valid === 1'b1)
         take({8'h1, 40'h0, reply_status, reply_cmd});
      if (jump_valid === 1'b1)
         take({8'h2, 40'h0, jump_addr});
      if (restore_valid === 1'b1)
         take({8'h3, flags_out, pc_out, acc_out});
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {rst, direct_mode, irq_event} = {1'b1, 1'b1, 32'h0};
      new_ctx();
      repeat (10) @(negedge clk);
      rst = 1'b0;
      `CHK("global_en", 1'b0, global_en);
      `CHK("irq_enabled", 32'h0, irq_enabled);
      // vectors for sources 2..5, then 3 redefined
      for (int n = 2; n < 7; n++)
      begin
         ctx = rnd();
         vec[(n == 6) ? 3 : n] = ctx[15:0];
         cmd(CMD_VECTOR_DEFINE_CMD_DEF, (n == 6) ? 8'd3 : 8'(n), ctx[31:0], 1'b0, 64'h0);
      end
      cmd(CMD_IRQ_ENABLE, 8'd3, rnd(), 1'b0, 64'h0);
      `CHK("irq_enabled", 32'h8, irq_enabled);
      cmd(CMD_IRQ_ENABLE, IRQ_GLOBAL, rnd(), 1'b0, 64'h0);
      `CHK("global_en", 1'b1, global_en);
      `CHK("irq_enabled", 32'h8, irq_enabled);
      // source 5 is disabled, so only 3 enters
      new_ctx();
      q.push_back({8'h2, 40'h0, vec[3]});
      pulse(32'h28);
      repeat (4) @(negedge clk);
      `CHK("handler_active", 1'b1, handler_active);
      // handler returns; inputs moved on so restore must use the saved copy
      {acc_in, xreg_in} = {~acc_in, ~xreg_in};
      {flags_in, pc_in} = ~{flags_in, pc_in};
      // stimulus ends each handler with a return
      cmd(CMD_HANDLER_RET, IRQ_GLOBAL, rnd(), 1'b0, ctx);
      `CHK("handler_active", 1'b0, handler_active);
      `CHK("xreg_out", ~xreg_in, xreg_out);
      // spoilt frame leaves the enables alone
      cmd(CMD_IRQ_ENABLE, 8'd7, rnd(), 1'b1, 64'h0);
      `CHK("irq_enabled", 32'h8, irq_enabled);
      // global off holds the event back until global on
      cmd(CMD_IRQ_DISABLE, IRQ_GLOBAL, rnd(), 1'b0, 64'h0);
      `CHK("global_en", 1'b0, global_en);
      new_ctx();
      pulse(32'h8);
      repeat (6) @(negedge clk);
      `CHK("handler_active", 1'b0, handler_active);
      cmd(CMD_IRQ_ENABLE, IRQ_GLOBAL, rnd(), 1'b0, {8'h2, 40'h0, vec[3]});
      repeat (3) @(negedge clk);
      cmd(CMD_HANDLER_RET, 8'h00, rnd(), 1'b0, ctx);
      cmd(CMD_IRQ_DISABLE, 8'd3, rnd(), 1'b0, 64'h0);
      `CHK("irq_enabled", 32'h0, irq_enabled);
      pulse(32'h8);
      // no reply mode, then a frame for another address
      // stored-program style run: no replies expected
      direct_mode = 1'b0;
      cmd(CMD_IRQ_ENABLE, 8'd9, rnd(), 1'b0, 64'h0);
      `CHK("irq_enabled", 32'h200, irq_enabled);
      direct_mode = 1'b1;
      host_i.send(DEV + 8'h1, CMD_IRQ_ENABLE, 8'd11, 8'h0, 32'h0, 1'b0);
      repeat (6) @(negedge clk);
      `CHK("irq_enabled", 32'h200, irq_enabled);
      `CHK("notes_left", 32'h0, 32'(q.size()));
      stop_test();
   end
endmodule : testbench
